// >>> pkg/ocdc_pkg.sv
/*
 * Constants for the output channel four divider control block: the register
 * map, field positions, reset values, mux codes and the serial port states.
 * Assumes nothing of its surroundings.
 */
package ocdc_pkg;
	localparam int REG_W = 16;
	localparam logic [7:0] OFS_CTRL1 = 8'h36;
	localparam logic [7:0] OFS_DIVCFG = 8'h37;
	localparam logic [7:0] OFS_SMF = 8'h38;
	localparam logic [7:0] OFS_UPD = 8'h39;
	localparam logic [7:0] OFS_SUP = 8'h3A;
	localparam logic [7:0] OFS_COMMON = 8'h3B;
	localparam logic [15:0] RST_CTRL1 = 16'h0000;
	localparam logic [15:0] RST_DIVCFG = 16'h0000;
	localparam logic [15:0] RST_SMF = 16'h0004;
	localparam logic [15:0] RST_UPD = 16'h0071;
	localparam logic [15:0] RST_SUP = 16'h0008;
	localparam logic [15:0] RST_COMMON = 16'h0061;
	// bits 6-5 of the sync/mute/format word are not implemented
	localparam logic [15:0] SMF_MASK = 16'hFF9F;
	localparam int SRC_HI = 15;
	localparam int SRC_LO = 14;
	localparam int DIV_HI = 13;
	localparam int DLY_HI = 15;
	localparam int DLY_LO = 11;
	localparam int ALN_EN_BIT = 10;
	localparam int MSEL_BIT = 8;
	localparam int MUTE_BIT = 7;
	localparam int FMT_HI = 4;
	localparam int FMT_LO = 2;
	localparam int OSRC_HI = 1;
	localparam int CLEAN_BIT = 0;
	localparam int LOWSUP_BIT = 3;
	localparam int CHRST_BIT = 13;
	localparam logic [1:0] SRC_PRE_A = 2'h0;
	localparam logic [1:0] SRC_PRE_B = 2'h1;
	localparam logic [1:0] SRC_REF = 2'h3;
	localparam logic [1:0] OSRC_PREV = 2'h0;
	localparam logic [1:0] OSRC_OWN = 2'h1;
	localparam logic [1:0] OSRC_NEXT = 2'h2;
	localparam logic [2:0] FMT_OFF = 3'h0;
	// bus address of the serial port; value is arbitrary
	localparam logic [6:0] DEV_ADDR = 7'h2A;
	typedef enum logic [6:0] {
		ST_IDLE = 7'b0000001,
		ST_ADDR = 7'b0000010,
		ST_REG = 7'b0000100,
		ST_WR = 7'b0001000,
		ST_ACK = 7'b0010000,
		ST_RD = 7'b0100000,
		ST_RACK = 7'b1000000
	} ocdc_state_t;
endpackage : ocdc_pkg

// >>> rtl/ocdc_sync2.sv
/*
 * Two flip-flop synchroniser for a group of pin levels.
 * Assumes the inputs are asynchronous levels; outputs lag by two edges.
 */
`timescale 1ns/1ps
module ocdc_sync2 #(
	parameter int W = 1
) (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_q;
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			meta_q <= '0;
			q <= '0;
		end else begin
			meta_q <= d;
			q <= meta_q;
		end
	end
endmodule : ocdc_sync2

// >>> rtl/ocdc_divider.sv
/*
 * Channel four integer divider with source select, clean or immediate
 * update, reset hold and delayed alignment restart.
 * Assumes source levels are already synchronised to ref_clk and far slower
 * than it, so every rising source edge is seen as one tick.
 */
`timescale 1ns/1ps
module ocdc_divider (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic [2:0] src_lvl,
	input wire logic [1:0] cfg_src,
	input wire logic [13:0] cfg_div,
	input wire logic clean_mode,
	input wire logic align_en,
	input wire logic [4:0] align_delay,
	input wire logic sync_pulse,
	input wire logic hold_rst,
	output logic div_out
);
	import ocdc_pkg::*;
	logic [1:0] act_src_q;
	logic [13:0] act_div_q;
	logic [13:0] cnt_q;
	logic [4:0] dly_q;
	logic dly_run_q;
	logic [2:0] prev_q;
	wire sel_lvl = (act_src_q == SRC_PRE_A) ? src_lvl[0] :
		(act_src_q == SRC_PRE_B) ? src_lvl[1] :
		(act_src_q == SRC_REF) ? src_lvl[2] : 1'b0; // see [RULE_01]
	wire sel_prev = (act_src_q == SRC_PRE_A) ? prev_q[0] :
		(act_src_q == SRC_PRE_B) ? prev_q[1] :
		(act_src_q == SRC_REF) ? prev_q[2] : 1'b0;
	wire tick = sel_lvl & ~sel_prev;
	wire off = (act_div_q == 14'h0000); // see [RULE_02]
	// >= lets a smaller immediate value wrap at once, not after overflow
	wire wrap = tick && (cnt_q >= act_div_q - 14'h0001);
	// clean mode waits for the period boundary so no runt pulse escapes
	wire load_cfg = !clean_mode || off || wrap || hold_rst; // see [RULE_09]
	wire arm = sync_pulse && align_en; // see [RULE_04]
	wire restart_now = arm && (align_delay == 5'h00);
	wire restart_dly = dly_run_q && tick && (dly_q == 5'h01); // see [RULE_12]
	wire [13:0] half = act_div_q >> 1;
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			act_src_q <= 2'h0;
			act_div_q <= 14'h0000;
			prev_q <= 3'h0;
		end else begin
			prev_q <= src_lvl;
			if (load_cfg) begin
				act_src_q <= cfg_src;
				act_div_q <= cfg_div;
			end
		end
	end
	always_ff @(posedge ref_clk) begin
		if (srst || hold_rst || off) begin // see [RULE_11]
			cnt_q <= 14'h0000;
		end else if (restart_now || restart_dly) begin
			cnt_q <= 14'h0000;
		end else if (tick) begin
			cnt_q <= wrap ? 14'h0000 : cnt_q + 14'h0001;
		end
	end
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			dly_q <= 5'h00;
			dly_run_q <= 1'b0;
		end else if (hold_rst) begin
			// a channel reset drops any alignment still pending
			dly_run_q <= 1'b0;
		end else if (arm && !restart_now) begin
			dly_q <= align_delay; // see [RULE_03]
			dly_run_q <= 1'b1;
		end else if (restart_dly || restart_now) begin
			dly_run_q <= 1'b0;
		end else if (dly_run_q && tick) begin
			dly_q <= dly_q - 5'h01;
		end
	end
	assign div_out = (hold_rst || off) ? 1'b0 :
		(act_div_q == 14'h0001) ? sel_lvl : (cnt_q < half);

	sequence s_last_tick;
		dly_run_q && tick && (dly_q == 5'h01) && !hold_rst && !off;
	endsequence
	a_align_restart: assert property ( // see [RULE_12]
		@(posedge ref_clk) disable iff (srst)
		s_last_tick |=> (cnt_q == 14'h0000))
		else $error("divider did not restart after alignment delay");
	a_delay_load: assert property ( // see [RULE_03]
		@(posedge ref_clk) disable iff (srst)
		arm && !hold_rst && (align_delay != 5'h00) |=> dly_run_q &&
		(dly_q == $past(align_delay)))
		else $error("alignment delay not loaded");
	a_sync_ignored: assert property ( // see [RULE_04]
		@(posedge ref_clk) disable iff (srst)
		sync_pulse && !align_en && !dly_run_q |=> !dly_run_q)
		else $error("sync taken while alignment disabled");
	a_immediate_load: assert property ( // see [RULE_09]
		@(posedge ref_clk) disable iff (srst)
		!clean_mode |=> (act_div_q == $past(cfg_div)))
		else $error("immediate mode did not apply divide value");
	a_powered_down: assert property ( // see [RULE_02]
		@(posedge ref_clk) disable iff (srst)
		off |-> !div_out ##1 (cnt_q == 14'h0000))
		else $error("divider running while divide value is zero");
	a_hold_reset: assert property ( // see [RULE_11]
		@(posedge ref_clk) disable iff (srst)
		hold_rst [*2] |-> (cnt_q == 14'h0000) && !div_out)
		else $error("divider not held by channel reset");
	a_ref_source: assert property ( // see [RULE_01]
		@(posedge ref_clk) disable iff (srst)
		act_src_q == SRC_REF |-> tick == (src_lvl[2] && !prev_q[2]))
		else $error("reference source not selected");
endmodule : ocdc_divider

// >>> rtl/ocdc_channel4.sv
/*
 * Output channel four control: serial register port, channel registers,
 * divider, output mux, mute and buffer format control.
 * Assumes the serial pins, prescaler clocks, reference and sync arrive
 * asynchronously at pins, and neighbour channel clocks come from logic on
 * ref_clk. Source clocks must run well below half of ref_clk.
 */
// Notes on behaviour
// [RULE_01] Divider source field bits 15-14: 0 prescaler A, 1 prescaler B, 3 reference.
// [RULE_02] Divider output is input over the 14-bit value at 13-0; zero powers it down.
// [RULE_03] Bits 15-11 give the sync delay in divider input cycles of the selected source.
// [RULE_04] Bit 10 lets the channel take part in sync; at 0 sync events are ignored.
// [RULE_05] Bit 8 picks mute levels: 0 gives positive low, negative high; 1 the reverse.
// [RULE_06] Bit 7 at 1 stops the clock and holds mute levels; at 0 the clock returns.
// [RULE_07] Bits 4-2 pick buffer format 0 off, 1 LVDS, 2 HCSL, 3 CML, 4 LVPECL, reset 1.
// [RULE_08] Bits 1-0 drive from previous channel, own divider, next channel or ground.
// [RULE_09] Bit 0 of the update word picks immediate (0) or glitch-free (1) update, reset 1.
// [RULE_10] Software sets bit 3 of the supply word, 0 for 2.5/3.3 V, 1 for 1.8 V, reset 1.
// [RULE_11] Common word bit 13 at 1 holds every divider in reset, at 0 releases it.
// [RULE_12] A sync with alignment on restarts the divider after exactly the delay count.
`timescale 1ns/1ps
module ocdc_channel4 (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	input wire logic prescaler_a_in,
	input wire logic prescaler_b_in,
	input wire logic ref_in,
	input wire logic sync_in,
	input wire logic prev_channel_clk,
	input wire logic next_channel_clk,
	output logic out4_clk_p,
	output logic out4_clk_n,
	output logic out4_divider_clk,
	output logic [2:0] out4_buffer_format,
	output logic out4_buffer_enable,
	output logic out4_low_supply_flag
);
	import ocdc_pkg::*;
	logic [5:0] pins_s;
	logic scl_d1_q;
	logic sda_d1_q;
	logic sync_d1_q;
	ocdc_state_t state_q;
	ocdc_state_t ret_q;
	logic [3:0] bitcnt_q;
	logic [7:0] shift_q;
	logic [7:0] tx_q;
	logic [7:0] ptr_q;
	logic [7:0] hi_q;
	logic byte_lo_q;
	logic rw_q;
	logic nack_q;
	logic [15:0] ctrl1_q;
	logic [15:0] divcfg_q;
	logic [15:0] smf_q;
	logic [15:0] upd_q;
	logic [15:0] sup_q;
	logic [15:0] common_q;
	logic div_clk;

	ocdc_sync2 #(.W(6)) u_sync (
		.ref_clk(ref_clk),
		.srst(srst),
		.d({sync_in, ref_in, prescaler_b_in, prescaler_a_in, sda_in, scl_in}),
		.q(pins_s)
	);
	wire scl = pins_s[0];
	wire sda = pins_s[1];
	wire sync_lvl = pins_s[5];
	wire scl_rise = scl && !scl_d1_q;
	wire scl_fall = !scl && scl_d1_q;
	wire start_cond = scl && scl_d1_q && !sda && sda_d1_q;
	wire stop_cond = scl && scl_d1_q && sda && !sda_d1_q;
	wire sync_pulse = sync_lvl && !sync_d1_q;
	wire byte_done = (bitcnt_q == 4'h8);
	wire addr_ok = (shift_q[7:1] == DEV_ADDR);
	wire wr_word = (state_q == ST_WR) && scl_fall && byte_done && byte_lo_q;

	// read data; unmapped pointers read zero
	wire [15:0] rd_word = (ptr_q == OFS_CTRL1) ? ctrl1_q :
		(ptr_q == OFS_DIVCFG) ? divcfg_q :
		(ptr_q == OFS_SMF) ? (smf_q & SMF_MASK) :
		(ptr_q == OFS_UPD) ? upd_q :
		(ptr_q == OFS_SUP) ? sup_q :
		(ptr_q == OFS_COMMON) ? common_q : 16'h0000;
	wire [7:0] next_lo_byte = rd_word[7:0];
	wire [15:0] next_word = (ptr_q == OFS_CTRL1 - 8'h01) ? ctrl1_q :
		(ptr_q == OFS_CTRL1) ? divcfg_q :
		(ptr_q == OFS_DIVCFG) ? (smf_q & SMF_MASK) :
		(ptr_q == OFS_SMF) ? upd_q :
		(ptr_q == OFS_UPD) ? sup_q :
		(ptr_q == OFS_SUP) ? common_q : 16'h0000;
	wire [7:0] rd_byte = !byte_lo_q ? next_lo_byte : next_word[15:8];

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			scl_d1_q <= 1'b1;
			sda_d1_q <= 1'b1;
			sync_d1_q <= 1'b0;
		end else begin
			scl_d1_q <= scl;
			sda_d1_q <= sda;
			sync_d1_q <= sync_lvl;
		end
	end

	// serial port: address, register pointer, then 16-bit words high first
	always_ff @(posedge ref_clk) begin
		if (srst || stop_cond) begin
			state_q <= ST_IDLE;
			ret_q <= ST_IDLE;
			bitcnt_q <= 4'h0;
			sda_oe <= 1'b0;
			byte_lo_q <= 1'b0;
			nack_q <= 1'b0;
			rw_q <= 1'b0;
			shift_q <= 8'h00;
			tx_q <= 8'h00;
			hi_q <= 8'h00;
			ptr_q <= 8'h00;
		end else if (start_cond) begin
			state_q <= ST_ADDR;
			bitcnt_q <= 4'h0;
			sda_oe <= 1'b0;
			byte_lo_q <= 1'b0;
		end else if (scl_rise) begin
			if (state_q inside {ST_ADDR, ST_REG, ST_WR}) begin
				shift_q <= {shift_q[6:0], sda};
				bitcnt_q <= bitcnt_q + 4'h1;
			end else if (state_q == ST_RACK) begin
				nack_q <= sda;
			end
		end else if (scl_fall) begin
			unique case (state_q)
				ST_IDLE: begin
				end
				ST_ADDR, ST_REG, ST_WR: begin
					if (byte_done) begin
						bitcnt_q <= 4'h0;
						ret_q <= state_q;
						state_q <= ST_ACK;
						sda_oe <= 1'b1;
						if (state_q == ST_ADDR) begin
							rw_q <= shift_q[0];
							if (!addr_ok) begin
								state_q <= ST_IDLE;
								sda_oe <= 1'b0;
							end
						end else if (state_q == ST_REG) begin
							ptr_q <= shift_q;
							byte_lo_q <= 1'b0;
						end else if (!byte_lo_q) begin
							hi_q <= shift_q;
							byte_lo_q <= 1'b1;
						end else begin
							byte_lo_q <= 1'b0;
							ptr_q <= ptr_q + 8'h01;
						end
					end
				end
				ST_ACK: begin
					sda_oe <= 1'b0;
					if (ret_q == ST_ADDR && rw_q) begin
						state_q <= ST_RD;
						sda_oe <= ~rd_word[15];
						tx_q <= {rd_word[14:8], 1'b1};
						bitcnt_q <= 4'h1;
					end else begin
						state_q <= (ret_q == ST_ADDR) ? ST_REG : ST_WR;
					end
				end
				ST_RD: begin
					if (byte_done) begin
						sda_oe <= 1'b0;
						bitcnt_q <= 4'h0;
						state_q <= ST_RACK;
					end else begin
						sda_oe <= ~tx_q[7];
						tx_q <= {tx_q[6:0], 1'b1};
						bitcnt_q <= bitcnt_q + 4'h1;
					end
				end
				ST_RACK: begin
					if (nack_q) begin
						state_q <= ST_IDLE;
					end else begin
						// auto-increment after the low byte of each word
						if (byte_lo_q) begin
							ptr_q <= ptr_q + 8'h01;
						end
						byte_lo_q <= !byte_lo_q;
						state_q <= ST_RD;
						sda_oe <= ~rd_byte[7];
						tx_q <= {rd_byte[6:0], 1'b1};
						bitcnt_q <= 4'h1;
					end
				end
			endcase
		end
	end

	// register file; writes land when the low byte of a word is acked
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			ctrl1_q <= RST_CTRL1;
			divcfg_q <= RST_DIVCFG;
			smf_q <= RST_SMF; // see [RULE_07]
			upd_q <= RST_UPD;
			sup_q <= RST_SUP; // see [RULE_10]
			common_q <= RST_COMMON;
		end else if (wr_word) begin
			if (ptr_q == OFS_CTRL1) ctrl1_q <= {hi_q, shift_q};
			if (ptr_q == OFS_DIVCFG) divcfg_q <= {hi_q, shift_q};
			if (ptr_q == OFS_SMF) smf_q <= {hi_q, shift_q} & SMF_MASK;
			if (ptr_q == OFS_UPD) upd_q <= {hi_q, shift_q};
			if (ptr_q == OFS_SUP) sup_q <= {hi_q, shift_q};
			if (ptr_q == OFS_COMMON) common_q <= {hi_q, shift_q};
		end
	end

	wire [1:0] out4_divider_source_select = divcfg_q[SRC_HI:SRC_LO];
	wire [13:0] out4_divide_value = divcfg_q[DIV_HI:0];
	wire [4:0] out4_align_delay = smf_q[DLY_HI:DLY_LO];
	wire out4_align_enable = smf_q[ALN_EN_BIT];
	wire out4_silence_level_select = smf_q[MSEL_BIT];
	wire out4_silence = smf_q[MUTE_BIT];
	wire [2:0] fmt = smf_q[FMT_HI:FMT_LO];
	wire [1:0] out4_output_source = smf_q[OSRC_HI:0];
	wire out4_clean_update_mode = upd_q[CLEAN_BIT];
	wire all_channel_reset = common_q[CHRST_BIT];

	ocdc_divider u_div (
		.ref_clk(ref_clk),
		.srst(srst),
		.src_lvl(pins_s[4:2]),
		.cfg_src(out4_divider_source_select), // see [RULE_01]
		.cfg_div(out4_divide_value), // see [RULE_02]
		.clean_mode(out4_clean_update_mode), // see [RULE_09]
		.align_en(out4_align_enable), // see [RULE_04]
		.align_delay(out4_align_delay), // see [RULE_03]
		.sync_pulse(sync_pulse),
		.hold_rst(all_channel_reset), // see [RULE_11]
		.div_out(div_clk)
	);

	wire mux_clk = (out4_output_source == OSRC_PREV) ? prev_channel_clk :
		(out4_output_source == OSRC_OWN) ? div_clk :
		(out4_output_source == OSRC_NEXT) ? next_channel_clk :
		1'b0; // see [RULE_08]
	wire buf_on = (fmt != FMT_OFF); // see [RULE_07]
	// mute holds a static pair instead of gating, so the receiver sees a
	// defined differential level rather than a floating pair
	wire p_d = !buf_on ? 1'b0 :
		out4_silence ? out4_silence_level_select : mux_clk; // see [RULE_06]
	wire n_d = !buf_on ? 1'b0 :
		out4_silence ? !out4_silence_level_select : !mux_clk; // see [RULE_05]

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			out4_clk_p <= 1'b0;
			out4_clk_n <= 1'b0;
			out4_divider_clk <= 1'b0;
			out4_buffer_format <= RST_SMF[FMT_HI:FMT_LO];
			out4_buffer_enable <= 1'b0;
			out4_low_supply_flag <= RST_SUP[LOWSUP_BIT];
			sda_out <= 1'b0;
		end else begin
			out4_clk_p <= p_d;
			out4_clk_n <= n_d;
			out4_divider_clk <= div_clk;
			out4_buffer_format <= fmt;
			out4_buffer_enable <= buf_on;
			out4_low_supply_flag <= sup_q[LOWSUP_BIT];
			sda_out <= 1'b0;
		end
	end

	a_mute_levels: assert property ( // see [RULE_05]
		@(posedge ref_clk) disable iff (srst)
		out4_silence && buf_on |=> out4_clk_p == $past(smf_q[MSEL_BIT]) &&
		out4_clk_n == !$past(smf_q[MSEL_BIT]))
		else $error("muted output not at selected levels");
	a_unmute_clock: assert property ( // see [RULE_06]
		@(posedge ref_clk) disable iff (srst)
		!out4_silence && buf_on && out4_output_source == OSRC_OWN
		|=> out4_clk_p == $past(div_clk) && out4_clk_n == !out4_clk_p)
		else $error("unmuted output does not follow divider");
	a_ground_sel: assert property ( // see [RULE_08]
		@(posedge ref_clk) disable iff (srst)
		(out4_output_source == 2'h3) && !out4_silence |=> !out4_clk_p)
		else $error("ground source not driving low");
	a_format_off: assert property ( // see [RULE_07]
		@(posedge ref_clk) disable iff (srst)
		fmt == FMT_OFF |=> !out4_buffer_enable && !out4_clk_p && !out4_clk_n)
		else $error("disabled buffer still active");
endmodule : ocdc_channel4

// >>> verification/ocdc_channel4_tb.sv
/*
 * Self-checking testbench for ocdc_channel4: register access over the serial
 * pins, format, mute, output mux, divider source, reset hold and alignment.
 * Assumes sda has a pull-up, modelled here, and slow source clocks.
 */
`timescale 1ns/1ps
module ocdc_channel4_tb;
	import ocdc_pkg::*;
	logic ref_clk = 1'b0;
	logic srst = 1'b1;
	logic scl = 1'b1;
	logic sda_drv = 1'b1;
	logic [2:0] src = 3'h0;
	logic sync_pin = 1'b0;
	logic prev_clk = 1'b0;
	logic next_clk = 1'b0;
	logic sda_out, sda_oe, clk_p, clk_n, div_clk, buf_en, low_sup;
	logic [2:0] buf_fmt;
	logic div_clk_q = 1'b0;
	logic sda_line;
	int rises = 0;
	// only the edge counter writes rises; scenarios note a base instead
	int rise_base = 0;
	int err_total = 0;
	int checks = 0;
	// open drain: the device can only pull the line low
	assign sda_line = sda_drv & ~sda_oe;
	always #10 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		div_clk_q <= div_clk;
		if (div_clk && !div_clk_q) rises <= rises + 1;
	end
	ocdc_channel4 ocdc_channel4_inst (
		.ref_clk(ref_clk), .srst(srst), .scl_in(scl), .sda_in(sda_line),
		.sda_out(sda_out), .sda_oe(sda_oe), .prescaler_a_in(src[0]),
		.prescaler_b_in(src[1]), .ref_in(src[2]), .sync_in(sync_pin),
		.prev_channel_clk(prev_clk), .next_channel_clk(next_clk),
		.out4_clk_p(clk_p), .out4_clk_n(clk_n), .out4_divider_clk(div_clk),
		.out4_buffer_format(buf_fmt), .out4_buffer_enable(buf_en),
		.out4_low_supply_flag(low_sup)
	);
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : cyc
	task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected word at %0t: got %h exp %h", $time, got, exp);
		end
	endtask : chk_word
	task automatic chk_bit(input logic got, input logic exp);
		checks++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected bit at %0t: got %h exp %h", $time, got, exp);
		end
	endtask : chk_bit
	task automatic wrap_up;
		$display("checks %0d err_total %0d", checks, err_total);
		if (err_total == 0 && checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : wrap_up
	// one bit: data set while scl low, scl high for 5 cycles and low for 7 (2 then 5)
	task automatic sbit(input logic b, output logic r);
		sda_drv = b;
		cyc(5);
		scl = 1'b1;
		cyc(5);
		r = sda_line;
		scl = 1'b0;
		cyc(2);
	endtask : sbit
	task automatic sbyte(input logic [7:0] b, input logic nine,
		output logic [7:0] r, output logic ack);
		logic a;
		for (int i = 7; i >= 0; i--) begin
			sbit(b[i], a);
			r[i] = a;
		end
		sbit(nine, ack);
	endtask : sbyte
	task automatic wbyte(input logic [7:0] b);
		logic [7:0] r;
		logic a;
		sbyte(b, 1'b1, r, a);
		chk_bit(a, 1'b0);
	endtask : wbyte
	task automatic start_c;
		sda_drv = 1'b1;
		cyc(5);
		scl = 1'b1;
		cyc(5);
		sda_drv = 1'b0;
		cyc(5);
		scl = 1'b0;
		cyc(5);
	endtask : start_c
	task automatic stop_c;
		sda_drv = 1'b0;
		cyc(5);
		scl = 1'b1;
		cyc(5);
		sda_drv = 1'b1;
		cyc(5);
	endtask : stop_c
	task automatic reg_wr(input logic [7:0] ofs, input logic [15:0] d);
		start_c();
		wbyte({DEV_ADDR, 1'b0});
		wbyte(ofs);
		wbyte(d[15:8]);
		wbyte(d[7:0]);
		stop_c();
		cyc(4);
	endtask : reg_wr
	task automatic rd_chk(input logic [7:0] ofs, input logic [15:0] exp);
		logic [15:0] d;
		logic a;
		start_c();
		wbyte({DEV_ADDR, 1'b0});
		wbyte(ofs);
		start_c();
		wbyte({DEV_ADDR, 1'b1});
		sbyte(8'hFF, 1'b0, d[15:8], a);
		sbyte(8'hFF, 1'b1, d[7:0], a);
		stop_c();
		chk_word(d, exp);
	endtask : rd_chk
	task automatic pulse(input int idx, input int n);
		repeat (n) begin
			src[idx] = 1'b1;
			cyc(6);
			src[idx] = 1'b0;
			cyc(6);
		end
	endtask : pulse
	// counter back to zero through the shared channel reset bit
	task automatic chan_rst;
		reg_wr(OFS_COMMON, RST_COMMON | 16'h2000);
		reg_wr(OFS_COMMON, RST_COMMON);
		cyc(10);
	endtask : chan_rst
	task automatic t_reset;
		logic [7:0] r;
		logic a;
		rd_chk(OFS_CTRL1, RST_CTRL1);
		rd_chk(OFS_DIVCFG, RST_DIVCFG);
		rd_chk(OFS_SMF, RST_SMF);
		rd_chk(OFS_UPD, RST_UPD);
		rd_chk(OFS_SUP, RST_SUP);
		rd_chk(OFS_COMMON, RST_COMMON);
		rd_chk(8'h40, 16'h0000);
		chk_word({13'h0000, buf_fmt}, 16'h0001);
		chk_bit(buf_en, 1'b1);
		chk_bit(low_sup, 1'b1);
		chk_bit(sda_out, 1'b0);
		start_c();
		sbyte({DEV_ADDR ^ 7'h01, 1'b0}, 1'b1, r, a);
		stop_c();
		chk_bit(a, 1'b1);
		reg_wr(OFS_SUP, 16'h0000);
		chk_bit(low_sup, 1'b0);
		rd_chk(OFS_SUP, 16'h0000);
		reg_wr(OFS_CTRL1, 16'hA5C3);
		rd_chk(OFS_CTRL1, 16'hA5C3);
		reg_wr(OFS_SMF, 16'hFFFF);
		rd_chk(OFS_SMF, SMF_MASK);
	endtask : t_reset
	task automatic t_format;
		for (int f = 0; f < 5; f++) begin
			reg_wr(OFS_SMF, {11'h000, 3'(f), 2'h1});
			chk_word({13'h0000, buf_fmt}, 16'(f));
			chk_bit(buf_en, f != 0);
		end
	endtask : t_format
	task automatic mux_case(input logic [1:0] code, input logic pv,
		input logic nv, input logic exp);
		prev_clk = pv;
		next_clk = nv;
		reg_wr(OFS_SMF, {14'h0001, code});
		chk_bit(clk_p, exp);
	endtask : mux_case
	task automatic t_mute_mux;
		reg_wr(OFS_DIVCFG, 16'h0000);
		prev_clk = 1'b1;
		reg_wr(OFS_SMF, 16'h0085);
		chk_bit(clk_p, 1'b0);
		chk_bit(clk_n, 1'b1);
		reg_wr(OFS_SMF, 16'h0184);
		chk_bit(clk_p, 1'b1);
		chk_bit(clk_n, 1'b0);
		prev_clk = 1'b0;
		cyc(4);
		chk_bit(clk_p, 1'b1);
		prev_clk = 1'b1;
		reg_wr(OFS_SMF, 16'h0004);
		chk_bit(clk_p, 1'b1);
		mux_case(2'h0, 1'b1, 1'b0, 1'b1);
		mux_case(2'h2, 1'b1, 1'b0, 1'b0);
		mux_case(2'h2, 1'b0, 1'b1, 1'b1);
		mux_case(2'h3, 1'b1, 1'b1, 1'b0);
		mux_case(2'h1, 1'b1, 1'b1, 1'b0);
	endtask : t_mute_mux
	// edges on another source first must leave the divider untouched
	task automatic src_case(input logic [1:0] code, input int idx,
		input int other);
		reg_wr(OFS_DIVCFG, {code, 14'h0004});
		chan_rst();
		rise_base = rises;
		pulse(other, 8);
		pulse(idx, 8);
		chk_word(16'(rises - rise_base), 16'h0002);
	endtask : src_case
	task automatic t_div;
		reg_wr(OFS_UPD, 16'h0070);
		reg_wr(OFS_SMF, 16'h0005);
		src_case(SRC_PRE_A, 0, 1);
		src_case(SRC_PRE_B, 1, 2);
		src_case(SRC_REF, 2, 0);
		reg_wr(OFS_DIVCFG, 16'h0000);
		rise_base = rises;
		pulse(0, 8);
		chk_word(16'(rises - rise_base), 16'h0000);
		chk_bit(div_clk, 1'b0);
		reg_wr(OFS_DIVCFG, 16'h0004);
		reg_wr(OFS_COMMON, RST_COMMON | 16'h2000);
		rise_base = rises;
		pulse(0, 8);
		chk_word(16'(rises - rise_base), 16'h0000);
		chk_bit(div_clk, 1'b0);
		reg_wr(OFS_COMMON, RST_COMMON);
	endtask : t_div
	// clean update keeps the old period of 8 running until it wraps,
	// then the new value of 2 takes over
	task automatic t_clean;
		reg_wr(OFS_UPD, RST_UPD);
		reg_wr(OFS_DIVCFG, 16'h0008);
		chan_rst();
		pulse(0, 4);
		reg_wr(OFS_DIVCFG, 16'h0002);
		pulse(0, 3);
		chk_bit(div_clk, 1'b0);
		pulse(0, 1);
		chk_bit(div_clk, 1'b1);
		pulse(0, 1);
		chk_bit(div_clk, 1'b0);
	endtask : t_clean
	// counter parked at 4 of 8 (output low) before the sync arrives
	task automatic align_case(input logic en, input logic [4:0] dly,
		input int n, input logic exp);
		reg_wr(OFS_SMF, {dly, en, 10'h005});
		reg_wr(OFS_DIVCFG, 16'h0008);
		chan_rst();
		pulse(0, 4);
		sync_pin = 1'b1;
		cyc(4);
		sync_pin = 1'b0;
		cyc(8);
		pulse(0, n);
		cyc(6);
		chk_bit(div_clk, exp);
	endtask : align_case
	task automatic t_align;
		align_case(1'b0, 5'h00, 0, 1'b0);
		align_case(1'b1, 5'h00, 0, 1'b1);
		align_case(1'b1, 5'h03, 2, 1'b0);
		align_case(1'b1, 5'h03, 3, 1'b1);
	endtask : t_align
	initial begin
		repeat (95000) @(posedge ref_clk);
		err_total++;
		wrap_up();
	end
	initial begin
		repeat (5) @(posedge ref_clk);
		#1;
		srst = 1'b0;
		cyc(4);
		t_reset();
		t_format();
		t_mute_mux();
		t_div();
		t_clean();
		t_align();
		wrap_up();
	end
endmodule : ocdc_channel4_tb
